/* File: hw/vfe_pkg.sv */
// Purpose: Shared constants for the virtual-flash emulation remap block
// Assumes: 32-bit byte addresses, classic Wishbone register slave
// Notes:   Register offsets are byte addresses of aligned words

package vfe_pkg;

  // ****************************************************************
  // Address map
  // ****************************************************************
  localparam logic [31:0] VFE_LARGE_WIN_BASE = 32'h0080_4000;
  localparam logic [31:0] VFE_SMALL0_WIN_BASE = 32'h0080_6000;
  localparam logic [31:0] VFE_SMALL1_WIN_BASE = 32'h0080_7000;
  localparam logic [31:0] VFE_RAM_BASE = 32'h0080_4000;
  localparam logic [31:0] VFE_RAM_LAST = 32'h0080_7FFF;
  localparam logic [31:0] VFE_FLASH_LAST_512K = 32'h0007_FFFF;
  localparam logic [31:0] VFE_FLASH_LAST_384K = 32'h0005_FFFF;
  localparam logic [31:0] VFE_FLASH_LAST_256K = 32'h0003_FFFF;
  localparam int unsigned VFE_LARGE_SHIFT = 13;
  localparam int unsigned VFE_SMALL_SHIFT = 12;
  localparam int unsigned VFE_LARGE_W = 6;
  localparam int unsigned VFE_SMALL_W = 7;

  // ****************************************************************
  // Registers
  // ****************************************************************
  localparam logic [4:0] VFE_REG_CTRL = 5'h00;
  localparam logic [4:0] VFE_REG_LBANK0 = 5'h04;
  localparam logic [4:0] VFE_REG_SBANK0 = 5'h08;
  localparam logic [4:0] VFE_REG_SBANK1 = 5'h0C;
  localparam logic [4:0] VFE_REG_STATUS = 5'h10;
  localparam int unsigned VFE_CTRL_EN_BIT = 0;
  localparam int unsigned VFE_CTRL_VAR_LSB = 1;
  localparam logic [1:0] VFE_CTRL_VAR_RST = 2'h0;
  localparam logic [5:0] VFE_LBANK_RST = 6'h00;
  localparam logic [6:0] VFE_SBANK_RST = 7'h00;
  localparam logic [15:0] VFE_COUNT_RST = 16'h0000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    VFE_VAR_512K = 2'h0,
    VFE_VAR_384K = 2'h1,
    VFE_VAR_256K = 2'h3
  } vfe_variant_t;

  typedef enum logic [1:0] {
    VFE_TGT_NONE  = 2'h0,
    VFE_TGT_FLASH = 2'h1,
    VFE_TGT_RAM   = 2'h3
  } vfe_target_t;

  // Last flash byte for a variant code; unused codes take the smallest part
  function automatic logic [31:0] vfe_flash_last(input logic [1:0] variant);
    logic [31:0] last;
    last = VFE_FLASH_LAST_256K;
    if (variant == VFE_VAR_512K) begin
      last = VFE_FLASH_LAST_512K;
    end else if (variant == VFE_VAR_384K) begin
      last = VFE_FLASH_LAST_384K;
    end
    return last;
  endfunction

endpackage

/* File: hw/vfe_match.sv */
// Purpose: Combinational bank match and address translation
// Assumes: Inputs stable within the cycle
// Notes:   No storage; the top registers the result

`timescale 1ns/1ps
`default_nettype none

module vfe_match (
  input  wire logic [31:0] addr_i,
  input  wire logic        enable_i,
  input  wire logic [1:0]  variant_i,
  input  wire logic [5:0]  large_bank_select_0_i,
  input  wire logic [6:0]  small_bank_select_0_i,
  input  wire logic [6:0]  small_bank_select_1_i,
  output logic [31:0]      addr_o,
  output vfe_pkg::vfe_target_t target_o,
  output logic [2:0]       hit_o
);

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire logic [31:0] flash_last = vfe_pkg::vfe_flash_last(variant_i);
  wire logic in_flash = (addr_i <= flash_last);
  wire logic in_ram = (addr_i >= vfe_pkg::VFE_RAM_BASE) && (addr_i <= vfe_pkg::VFE_RAM_LAST);
  wire logic [5:0] large_idx = addr_i[vfe_pkg::VFE_LARGE_SHIFT +: vfe_pkg::VFE_LARGE_W];
  wire logic [6:0] small_idx = addr_i[vfe_pkg::VFE_SMALL_SHIFT +: vfe_pkg::VFE_SMALL_W];
  wire logic large_hit = enable_i && in_flash && (large_idx == large_bank_select_0_i);
  wire logic small0_hit = enable_i && in_flash && (small_idx == small_bank_select_0_i);
  wire logic small1_hit = enable_i && in_flash && (small_idx == small_bank_select_1_i);
  wire logic [31:0] large_addr = vfe_pkg::VFE_LARGE_WIN_BASE | {19'h00000, addr_i[12:0]};
  wire logic [31:0] small0_addr = vfe_pkg::VFE_SMALL0_WIN_BASE | {20'h00000, addr_i[11:0]};
  wire logic [31:0] small1_addr = vfe_pkg::VFE_SMALL1_WIN_BASE | {20'h00000, addr_i[11:0]};

  // ****************************************************************
  // Select by priority
  // ****************************************************************
  assign hit_o = {small1_hit, small0_hit, large_hit};
  assign addr_o = large_hit ? large_addr :
                  small0_hit ? small0_addr :
                  small1_hit ? small1_addr : addr_i;
  assign target_o = (large_hit || small0_hit || small1_hit || in_ram) ? vfe_pkg::VFE_TGT_RAM :
                    in_flash ? vfe_pkg::VFE_TGT_FLASH : vfe_pkg::VFE_TGT_NONE;

endmodule

`default_nettype wire

/* File: hw/vfe_remap.sv */
// Purpose: Virtual-flash emulation remap with Wishbone register slave
// Assumes: CPU access port on the same clock; one cycle of remap latency
// Notes:   Remapped accesses, reads and writes alike, reach internal RAM

`timescale 1ns/1ps
`default_nettype none

module vfe_remap (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // CPU or debugger access
  input  wire logic        cpu_req_i,
  input  wire logic        cpu_we_i,
  input  wire logic [31:0] cpu_addr_i,
  // Memory side access
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic [31:0]      mem_addr_o,
  output logic             mem_flash_sel_o,
  output logic             mem_ram_sel_o,
  output logic             mem_remapped_o
);

  // ****************************************************************
  // Configuration and state
  // ****************************************************************
  logic        enable;
  logic [1:0]  variant;
  logic [5:0]  large_bank_select_0;
  logic [6:0]  small_bank_select_0;
  logic [6:0]  small_bank_select_1;
  logic [2:0]  last_hit;
  logic [15:0] remap_count;
  logic [31:0] match_addr;
  logic [2:0]  match_hit;
  vfe_pkg::vfe_target_t match_target;

  vfe_match u_match (
    .addr_i                (cpu_addr_i),
    .enable_i              (enable),
    .variant_i             (variant),
    .large_bank_select_0_i (large_bank_select_0),
    .small_bank_select_0_i (small_bank_select_0),
    .small_bank_select_1_i (small_bank_select_1),
    .addr_o                (match_addr),
    .target_o              (match_target),
    .hit_o                 (match_hit)
  );

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire logic bus_go = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic bus_wr = bus_go && wb_we_i;
  wire logic sel_ctrl = (wb_adr_i == vfe_pkg::VFE_REG_CTRL);
  wire logic sel_lbank = (wb_adr_i == vfe_pkg::VFE_REG_LBANK0);
  wire logic sel_sbank0 = (wb_adr_i == vfe_pkg::VFE_REG_SBANK0);
  wire logic sel_sbank1 = (wb_adr_i == vfe_pkg::VFE_REG_SBANK1);
  wire logic sel_status = (wb_adr_i == vfe_pkg::VFE_REG_STATUS);
  wire logic wr_ctrl = bus_wr && sel_ctrl && wb_sel_i[0];
  wire logic wr_lbank = bus_wr && sel_lbank && wb_sel_i[0];
  wire logic wr_sbank0 = bus_wr && sel_sbank0 && wb_sel_i[0];
  wire logic wr_sbank1 = bus_wr && sel_sbank1 && wb_sel_i[0];
  wire logic any_hit = |match_hit;
  wire logic cpu_remap = cpu_req_i && any_hit;

  wire logic [31:0] ctrl_word = {29'h00000000, variant, enable};
  wire logic [31:0] status_word = {remap_count, 13'h0000, last_hit};
  wire logic [31:0] next_rdata =
    sel_ctrl ? ctrl_word :
    sel_lbank ? {26'h0000000, large_bank_select_0} :
    sel_sbank0 ? {25'h0000000, small_bank_select_0} :
    sel_sbank1 ? {25'h0000000, small_bank_select_1} :
    sel_status ? status_word : 32'h0000_0000;
  wire logic [15:0] next_count = remap_count + 16'h0001;

  // ****************************************************************
  // Wishbone answer
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_go;
      wb_dat_o <= bus_go ? next_rdata : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable  <= 1'b0;
      variant <= vfe_pkg::VFE_CTRL_VAR_RST;
    end else if (wr_ctrl) begin
      enable  <= wb_dat_i[vfe_pkg::VFE_CTRL_EN_BIT];
      variant <= wb_dat_i[vfe_pkg::VFE_CTRL_VAR_LSB +: 2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      large_bank_select_0 <= vfe_pkg::VFE_LBANK_RST;
    end else if (wr_lbank) begin
      large_bank_select_0 <= wb_dat_i[5:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      small_bank_select_0 <= vfe_pkg::VFE_SBANK_RST;
    end else if (wr_sbank0) begin
      small_bank_select_0 <= wb_dat_i[6:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      small_bank_select_1 <= vfe_pkg::VFE_SBANK_RST;
    end else if (wr_sbank1) begin
      small_bank_select_1 <= wb_dat_i[6:0];
    end
  end

  // ****************************************************************
  // Status
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_hit    <= 3'h0;
      remap_count <= vfe_pkg::VFE_COUNT_RST;
    end else if (cpu_req_i) begin
      last_hit <= match_hit;
      if (cpu_remap) begin
        remap_count <= next_count;
      end
    end
  end

  // ****************************************************************
  // Memory access stage
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_req_o       <= 1'b0;
      mem_we_o        <= 1'b0;
      mem_addr_o      <= 32'h0000_0000;
      mem_flash_sel_o <= 1'b0;
      mem_ram_sel_o   <= 1'b0;
      mem_remapped_o  <= 1'b0;
    end else begin
      mem_req_o       <= cpu_req_i;
      mem_we_o        <= cpu_req_i && cpu_we_i;
      mem_addr_o      <= cpu_req_i ? match_addr : 32'h0000_0000;
      mem_flash_sel_o <= cpu_req_i && (match_target == vfe_pkg::VFE_TGT_FLASH);
      mem_ram_sel_o   <= cpu_req_i && (match_target == vfe_pkg::VFE_TGT_RAM);
      mem_remapped_o  <= cpu_remap;
    end
  end

endmodule

`default_nettype wire

/* File: tb/vfe_remap_sva.sv */
// Purpose: Port checker for the remap block
// Assumes: Synchronous active-high reset
// Notes:   Bound to every remap instance
`timescale 1ns/1ps
`default_nettype none
module vfe_remap_sva (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [4:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        cpu_req_i,
  input wire logic        cpu_we_i,
  input wire logic [31:0] cpu_addr_i,
  input wire logic        mem_req_o,
  input wire logic        mem_we_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic        mem_flash_sel_o,
  input wire logic        mem_ram_sel_o,
  input wire logic        mem_remapped_o
);
  // ****************
  // Assertions
  // ****************
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ack_after_take_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat not zero");
  req_follow_a: assert property (mem_req_o == $past(cpu_req_i)) else $error("req lag");
  we_follow_a: assert property (mem_we_o == ($past(cpu_req_i) && $past(cpu_we_i)))
    else $error("we lag");
  remap_window_a: assert property (mem_remapped_o |-> mem_ram_sel_o
    && mem_addr_o[31:14] == 18'h00201 && mem_addr_o[11:0] == $past(cpu_addr_i[11:0]))
    else $error("bad window");
  range_limit_a: assert property ($past(cpu_addr_i) > 32'h0007FFFF |-> !mem_remapped_o)
    else $error("remap beyond flash");
  flash_pass_a: assert property (mem_flash_sel_o |-> !mem_ram_sel_o
    && mem_addr_o == $past(cpu_addr_i)) else $error("flash addr changed");
  ram_direct_a: assert property ($past(cpu_req_i) && $past(cpu_addr_i[31:14]) == 18'h00201
    |-> mem_ram_sel_o && !mem_remapped_o && mem_addr_o == $past(cpu_addr_i))
    else $error("ram direct wrong");
  idle_quiet_a: assert property (!mem_req_o |-> mem_addr_o == 32'h0 && !mem_flash_sel_o
    && !mem_ram_sel_o) else $error("idle not quiet");
  cover property (mem_remapped_o && mem_we_o);
  cover property (mem_ram_sel_o && !mem_remapped_o);
  cover property (wb_ack_o && !wb_we_i);
endmodule
bind vfe_remap vfe_remap_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_req_i(cpu_req_i),
  .cpu_we_i(cpu_we_i), .cpu_addr_i(cpu_addr_i), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
  .mem_addr_o(mem_addr_o), .mem_flash_sel_o(mem_flash_sel_o),
  .mem_ram_sel_o(mem_ram_sel_o), .mem_remapped_o(mem_remapped_o));
`default_nettype wire

/* File: tb/vfe_cpu_model.sv */
// Purpose: CPU side access model
// Assumes: One request per access, same clock
// Notes:   Idle address is scrambled
`timescale 1ns/1ps
`default_nettype none
module vfe_cpu_model (
  input  wire logic        clk_i,
  output logic             req_o,
  output logic             we_o,
  output logic [31:0]      addr_o
);
  // ****************
  // Driver
  // ****************
  initial begin
    req_o = 1'b0;
    we_o = 1'b0;
    addr_o = 32'h0;
  end
  task automatic access(input logic we, input logic [31:0] a);
    @(posedge clk_i);
    req_o <= 1'b1;
    we_o <= we;
    addr_o <= a;
    @(posedge clk_i);
    req_o <= 1'b0;
    we_o <= ~we;
    addr_o <= ~a;
  endtask
endmodule
`default_nettype wire

/* File: tb/test_vfe_remap.sv */
// Purpose: Self-checking bench for the remap block
// Assumes: Registered outputs, one cycle of latency
// Notes:   Expected codes are {flash, ram, remapped}
`timescale 1ns/1ps
`default_nettype none
module test_vfe_remap;
  localparam logic [2:0] F = 3'h4;
  localparam logic [2:0] R = 3'h3;
  localparam logic [2:0] D = 3'h2;
  localparam logic [2:0] N = 3'h0;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, cpu_req_i, cpu_we_i;
  logic [4:0] wb_adr_i = 5'h00;
  logic [3:0] wb_sel_i = 4'h0, sel = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, cpu_addr_i, mem_addr_o, q;
  logic mem_req_o, mem_we_o, mem_flash_sel_o, mem_ram_sel_o, mem_remapped_o;
  logic [15:0] n_remap = 16'h0;
  int n_checks = 0, n_mismatch = 0;
  always #5 clk_i = ~clk_i;
  vfe_remap DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_req_i(cpu_req_i), .cpu_we_i(cpu_we_i),
    .cpu_addr_i(cpu_addr_i), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .mem_flash_sel_o(mem_flash_sel_o),
    .mem_ram_sel_o(mem_ram_sel_o), .mem_remapped_o(mem_remapped_o));
  vfe_cpu_model u_cpu (.clk_i(clk_i), .req_o(cpu_req_i), .we_o(cpu_we_i), .addr_o(cpu_addr_i));
  // ****************
  // Tasks
  // ****************
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= sel;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(40'(q), 40'(e));
  endtask
  task automatic cpu(input logic we, input logic [31:0] a, input logic [31:0] e,
                     input logic [2:0] c);
    u_cpu.access(we, a);
    #1;
    chk({3'h0, mem_req_o, mem_we_o, mem_flash_sel_o, mem_ram_sel_o, mem_remapped_o,
         mem_addr_o}, {4'h1, we, c, e});
    if (c == R) n_remap++;
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int k = 0; k < 6; k++) rd(5'(k * 4), 32'h0);
    $display("test reset values done");
    wb(1'b1, vfe_pkg::VFE_REG_LBANK0, 32'h3);
    wb(1'b1, vfe_pkg::VFE_REG_SBANK0, 32'h5);
    wb(1'b1, vfe_pkg::VFE_REG_SBANK1, 32'h9);
    cpu(1'b0, 32'h7ABC, 32'h7ABC, F);
    wb(1'b1, vfe_pkg::VFE_REG_CTRL, 32'h1);
    rd(vfe_pkg::VFE_REG_LBANK0, 32'h3);
    cpu(1'b0, 32'h7ABC, 32'h805ABC, R);
    cpu(1'b0, 32'h6000, 32'h804000, R);
    cpu(1'b0, 32'h5123, 32'h806123, R);
    cpu(1'b1, 32'h9FFF, 32'h807FFF, R);
    cpu(1'b1, 32'h804010, 32'h804010, D);
    cpu(1'b0, 32'h8000, 32'h8000, F);
    $display("test bank remap done");
    wb(1'b1, vfe_pkg::VFE_REG_SBANK0, 32'h6);
    wb(1'b1, vfe_pkg::VFE_REG_SBANK1, 32'h6);
    cpu(1'b0, 32'h6010, 32'h804010, R);
    wb(1'b1, vfe_pkg::VFE_REG_LBANK0, 32'h0);
    sel = 4'hE;
    wb(1'b1, vfe_pkg::VFE_REG_SBANK0, 32'h7);
    sel = 4'hF;
    cpu(1'b0, 32'h6010, 32'h806010, R);
    rd(vfe_pkg::VFE_REG_SBANK0, 32'h6);
    rd(vfe_pkg::VFE_REG_STATUS, {n_remap, 13'h0000, 3'h6});
    $display("test priority done");
    wb(1'b1, vfe_pkg::VFE_REG_SBANK1, 32'h7F);
    cpu(1'b0, 32'h7F010, 32'h807010, R);
    wb(1'b1, vfe_pkg::VFE_REG_CTRL, 32'h3);
    rd(vfe_pkg::VFE_REG_CTRL, 32'h3);
    cpu(1'b0, 32'h7F010, 32'h7F010, N);
    wb(1'b1, vfe_pkg::VFE_REG_SBANK1, 32'h5F);
    cpu(1'b0, 32'h5F010, 32'h807010, R);
    wb(1'b1, vfe_pkg::VFE_REG_CTRL, 32'h7);
    cpu(1'b0, 32'h5F010, 32'h5F010, N);
    wb(1'b1, vfe_pkg::VFE_REG_CTRL, 32'h5);
    cpu(1'b0, 32'h5F010, 32'h5F010, N);
    wb(1'b1, vfe_pkg::VFE_REG_CTRL, 32'h0);
    cpu(1'b0, 32'h6010, 32'h6010, F);
    wb(1'b0, vfe_pkg::VFE_REG_STATUS, 32'h0);
    chk(40'(q), 40'({n_remap, 16'h0000}));
    $display("test variants done");
    wrap_up();
  end
endmodule
`default_nettype wire
